//--- verilog/rxam_upper.sv
`timescale 1ns/1ps
// Overview of operation
// - Region three hit subtracts sizes one and two, adds region three offset.
// - Fourth region spans sum of sizes one to three up to one to four.
// - Fourth region address is inbound plus offset four minus sizes one to three.
// - Size and offset fields use bits 31:2; bits 1:0 read zero, ignore writes.
// - Identity upper half always returns the part revision input.
// - Identity lower half always returns the part type input.
// - Region two spans size one up to sizes one plus two; translate accordingly.
module rxam_upper (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] region1_span,
	input  wire logic [31:0] region2_span,
	input  wire logic [31:0] region2_base_offset,
	input  wire logic        inbound_valid,
	input  wire logic [31:0] inbound_addr,
	output logic             xlat_valid,
	output logic [31:0]      xlat_addr,
	output logic [2:0]       xlat_region,
	input  wire logic [15:0] part_type_input,
	input  wire logic [15:0] part_revision_input
);

	// ****************************************
	// Register storage
	// ****************************************
	logic [29:0] region3_span;
	logic [29:0] region3_base_offset;
	logic [29:0] region4_span;
	logic [29:0] region4_base_offset;
	logic [15:0] part_type_sync;
	logic [15:0] part_rev_sync;

	rxam_sync #(
		.WIDTH    (rxam_pkg::ID_WIDTH)
	) u_type_sync (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.async_in (part_type_input),
		.sync_out (part_type_sync)
	);

	rxam_sync #(
		.WIDTH    (rxam_pkg::ID_WIDTH)
	) u_rev_sync (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.async_in (part_revision_input),
		.sync_out (part_rev_sync)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	wire         setup_phase = psel & ~penable;
	wire         wr_commit   = psel & penable & pready & pwrite;
	wire         hit_s3      = (paddr == rxam_pkg::OFS_REGION3_SPAN);
	wire         hit_o3      = (paddr == rxam_pkg::OFS_REGION3_BASE);
	wire         hit_s4      = (paddr == rxam_pkg::OFS_REGION4_SPAN);
	wire         hit_o4      = (paddr == rxam_pkg::OFS_REGION4_BASE);
	wire         hit_id      = (paddr == rxam_pkg::OFS_PART_IDENTITY);
	wire         mapped      = hit_s3 | hit_o3 | hit_s4 | hit_o4 | hit_id;
	wire  [29:0] wr_field    = pwdata[31:rxam_pkg::FIELD_LSB];
	wire  [31:0] id_word     = {part_rev_sync, part_type_sync};
	wire  [29:0] sel_field   = hit_s3 ? region3_span :
	                           hit_o3 ? region3_base_offset :
	                           hit_s4 ? region4_span :
	                           hit_o4 ? region4_base_offset : rxam_pkg::RESET_FIELD;
	wire  [31:0] field_word  = {sel_field, rxam_pkg::RESERVED_READ};
	wire  [31:0] next_prdata = (setup_phase & ~pwrite) ? (hit_id ? id_word : field_word)
	                           : rxam_pkg::RESET_WORD;

	// Zero-wait slave: setup then one access cycle with pready high
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= rxam_pkg::RESET_WORD;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase & ~mapped;
			prdata  <= next_prdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			region3_span        <= rxam_pkg::RESET_FIELD;
			region3_base_offset <= rxam_pkg::RESET_FIELD;
			region4_span        <= rxam_pkg::RESET_FIELD;
			region4_base_offset <= rxam_pkg::RESET_FIELD;
		end else if (wr_commit) begin
			if (hit_s3) region3_span <= wr_field;
			if (hit_o3) region3_base_offset <= wr_field;
			if (hit_s4) region4_span <= wr_field;
			if (hit_o4) region4_base_offset <= wr_field;
		end
	end

	// ****************************************
	// Inbound address translation
	// ****************************************
	wire  [31:0] size3      = {region3_span, rxam_pkg::RESERVED_READ};
	wire  [31:0] size4      = {region4_span, rxam_pkg::RESERVED_READ};
	wire  [31:0] offs3      = {region3_base_offset, rxam_pkg::RESERVED_READ};
	wire  [31:0] offs4      = {region4_base_offset, rxam_pkg::RESERVED_READ};
	// Extra bits keep the bounds from wrapping
	wire  [33:0] bound1     = {2'h0, region1_span};
	wire  [33:0] bound2     = bound1 + {2'h0, region2_span};
	wire  [33:0] bound3     = bound2 + {2'h0, size3};
	wire  [33:0] bound4     = bound3 + {2'h0, size4};
	wire  [33:0] addr_ext   = {2'h0, inbound_addr};
	wire         in_r2      = (addr_ext >= bound1) && (addr_ext < bound2);
	wire         in_r3      = (addr_ext >= bound2) && (addr_ext < bound3);
	wire         in_r4      = (addr_ext >= bound3) && (addr_ext < bound4);
	wire  [31:0] addr_r2    = inbound_addr + region2_base_offset - bound1[31:0];
	wire  [31:0] addr_r3    = inbound_addr + offs3 - bound2[31:0];
	wire  [31:0] addr_r4    = inbound_addr + offs4 - bound3[31:0];
	wire  [31:0] next_addr  = in_r2 ? addr_r2 : in_r3 ? addr_r3 : in_r4 ? addr_r4 : inbound_addr;
	wire  [2:0]  next_region = in_r2 ? rxam_pkg::REGION_TWO :
	                           in_r3 ? rxam_pkg::REGION_THREE :
	                           in_r4 ? rxam_pkg::REGION_FOUR : rxam_pkg::REGION_NONE;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			xlat_valid  <= 1'b0;
			xlat_addr   <= rxam_pkg::RESET_WORD;
			xlat_region <= rxam_pkg::REGION_NONE;
		end else begin
			xlat_valid <= inbound_valid;
			if (inbound_valid) begin
				xlat_addr   <= next_addr;
				xlat_region <= next_region;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_region3_xlat;
		@(posedge mclk) disable iff (!rst_b)
		(inbound_valid && in_r3) |=> (xlat_valid && xlat_region == rxam_pkg::REGION_THREE
			&& xlat_addr == $past(inbound_addr) + $past(offs3) - $past(region1_span) - $past(region2_span));
	endproperty
	a_region3_xlat: assert property (p_region3_xlat) else $error("region three translation wrong");

	property p_region4_select;
		@(posedge mclk) disable iff (!rst_b)
		(inbound_valid && !in_r2 && !in_r3 && {2'h0, inbound_addr} >= bound3 && {2'h0, inbound_addr} < bound4)
			|=> (xlat_region == rxam_pkg::REGION_FOUR);
	endproperty
	a_region4_select: assert property (p_region4_select) else $error("region four not selected");

	property p_region4_xlat;
		@(posedge mclk) disable iff (!rst_b)
		(inbound_valid && in_r4 && !in_r2 && !in_r3) |=> (xlat_addr == $past(inbound_addr) + $past(offs4)
			- $past(region1_span) - $past(region2_span) - $past(size3));
	endproperty
	a_region4_xlat: assert property (p_region4_xlat) else $error("region four translation wrong");

	property p_field_store;
		@(posedge mclk) disable iff (!rst_b)
		(wr_commit && hit_s4) |=> (region4_span == $past(pwdata[31:2])
			&& region4_base_offset == $past(region4_base_offset));
	endproperty
	a_field_store: assert property (p_field_store) else $error("span field store wrong");

	property p_id_rev;
		@(posedge mclk) disable iff (!rst_b)
		(setup_phase && !pwrite && hit_id) |=> (pready && prdata[31:16] == $past(part_rev_sync));
	endproperty
	a_id_rev: assert property (p_id_rev) else $error("identity revision half wrong");

	property p_id_type;
		@(posedge mclk) disable iff (!rst_b)
		(setup_phase && !pwrite && hit_id) |=> (prdata[15:0] == $past(part_type_sync) && !pslverr);
	endproperty
	a_id_type: assert property (p_id_type) else $error("identity type half wrong");

	property p_region2_xlat;
		@(posedge mclk) disable iff (!rst_b)
		(inbound_valid && in_r2) |=> (xlat_region == rxam_pkg::REGION_TWO
			&& xlat_addr == $past(inbound_addr) + $past(region2_base_offset) - $past(region1_span));
	endproperty
	a_region2_xlat: assert property (p_region2_xlat) else $error("region two translation wrong");

	property p_reset_clear;
		@(posedge mclk)
		!rst_b |=> (region3_span == 30'h0 && region3_base_offset == 30'h0
			&& region4_span == 30'h0 && region4_base_offset == 30'h0);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("region fields not cleared");

	property p_field_read;
		@(posedge mclk) disable iff (!rst_b)
		(setup_phase && !pwrite && hit_o4)
			|=> (pready && prdata == {$past(region4_base_offset), rxam_pkg::RESERVED_READ});
	endproperty
	a_field_read: assert property (p_field_read) else $error("offset field read wrong");

	property p_offset_store;
		@(posedge mclk) disable iff (!rst_b)
		(wr_commit && hit_o3) |=> (offs3 == {$past(pwdata[31:2]), rxam_pkg::RESERVED_READ});
	endproperty
	a_offset_store: assert property (p_offset_store) else $error("offset field store wrong");

	property p_no_region;
		@(posedge mclk) disable iff (!rst_b)
		(inbound_valid && !in_r2 && !in_r3 && !in_r4)
			|=> (xlat_region == rxam_pkg::REGION_NONE && xlat_addr == $past(inbound_addr));
	endproperty
	a_no_region: assert property (p_no_region) else $error("unmatched address altered");

endmodule

//--- verilog/rxam_pkg.sv
package rxam_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0]  OFS_REGION3_SPAN    = 8'h30;
	localparam logic [7:0]  OFS_REGION3_BASE    = 8'h34;
	localparam logic [7:0]  OFS_REGION4_SPAN    = 8'h38;
	localparam logic [7:0]  OFS_REGION4_BASE    = 8'h3C;
	localparam logic [7:0]  OFS_PART_IDENTITY   = 8'h40;

	// ****************************************
	// Field layout and reset values
	// ****************************************
	localparam int          FIELD_LSB           = 2;
	localparam int          FIELD_WIDTH         = 30;
	localparam logic [29:0] RESET_FIELD         = 30'h0000_0000;
	localparam logic [1:0]  RESERVED_READ       = 2'h0;
	localparam int          ID_REV_LSB          = 16;
	localparam int          ID_TYPE_LSB         = 0;
	localparam int          ID_WIDTH            = 16;
	localparam logic [15:0] RESET_ID            = 16'h0000;
	localparam logic [31:0] RESET_WORD          = 32'h0000_0000;

	// ****************************************
	// Region codes on the translated output
	// ****************************************
	localparam logic [2:0]  REGION_NONE         = 3'h0;
	localparam logic [2:0]  REGION_TWO          = 3'h2;
	localparam logic [2:0]  REGION_THREE        = 3'h3;
	localparam logic [2:0]  REGION_FOUR         = 3'h4;

endpackage

//--- verilog/rxam_sync.sv
`timescale 1ns/1ps
module rxam_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// Change accepted once stages two and three agree
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				sync_out <= stage3;
			end
		end
	end

endmodule

//--- tb/rxam_peer.sv
`timescale 1ns/1ps
// ****************************************
// Remote peer issuing inbound addresses
// ****************************************
module rxam_peer (
	input  wire logic        mclk,
	output logic             inbound_valid,
	output logic [31:0]      inbound_addr
);
	initial begin
		inbound_valid = 1'b0;
		inbound_addr  = 32'h0;
	end
	// One strobe, then scramble the stale address
	task automatic send(input logic [31:0] a);
		@(posedge mclk);
		inbound_valid <= 1'b1;
		inbound_addr  <= a;
		@(posedge mclk);
		inbound_valid <= 1'b0;
		inbound_addr  <= ~a;
	endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] region1_span = 32'h1000;
	logic [31:0] region2_span = 32'h1000;
	logic [31:0] region2_base_offset = 32'h8000_0000;
	logic        inbound_valid;
	logic [31:0] inbound_addr;
	logic        xlat_valid;
	logic [31:0] xlat_addr;
	logic [2:0]  xlat_region;
	logic [15:0] part_type_input = 16'hA5C3;
	logic [15:0] part_revision_input = 16'h1E2F;
	int          err_total = 0;
	int          checked = 0;
	logic [31:0] rd;
	logic        er;

	always #4 mclk = ~mclk;

	rxam_upper DUT (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.region1_span, .region2_span, .region2_base_offset, .inbound_valid, .inbound_addr, .xlat_valid,
		.xlat_addr, .xlat_region, .part_type_input, .part_revision_input);
	rxam_peer peer (.mclk, .inbound_valid, .inbound_addr);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic xl(input logic [31:0] a, input logic [31:0] ea, input logic [2:0] er3);
		peer.send(a);
		@(negedge mclk);
		chk("xlat_valid", {31'h0, xlat_valid}, 32'h1);
		chk("xlat_addr", xlat_addr, ea);
		chk("xlat_region", {29'h0, xlat_region}, {29'h0, er3});
	endtask
	task automatic end_of_test;
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'h30 + 8'(4 * i), 32'h0);
			chk("field after reset", rd, 32'h0);
		end
		xl(32'h2000, 32'h2000, rxam_pkg::REGION_NONE);
		apb(1'b0, 8'h44, 32'h0);
		chk("unmapped error", {31'h0, er}, 32'h1);
	endtask
	task automatic t_fields;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h30 + 8'(4 * i), 32'hC3A5_F00F ^ (32'h1110 * i));
			apb(1'b0, 8'h30 + 8'(4 * i), 32'h0);
			chk("field readback", rd, (32'hC3A5_F00F ^ (32'h1110 * i)) & 32'hFFFF_FFFC);
		end
	endtask
	task automatic t_ident;
		apb(1'b1, rxam_pkg::OFS_PART_IDENTITY, 32'h0);
		apb(1'b0, rxam_pkg::OFS_PART_IDENTITY, 32'h0);
		chk("identity", rd, 32'h1E2F_A5C3);
		part_type_input <= 16'h5A3C;
		part_revision_input <= 16'hE1F2;
		repeat (6) @(posedge mclk);
		apb(1'b0, rxam_pkg::OFS_PART_IDENTITY, 32'h0);
		chk("identity follows pins", rd, 32'hE1F2_5A3C);
	endtask
	task automatic t_xlat;
		apb(1'b1, 8'h30, 32'h2003);
		apb(1'b1, 8'h34, 32'h4000_0003);
		apb(1'b1, 8'h38, 32'h1002);
		apb(1'b1, 8'h3C, 32'h5000_0001);
		xl(32'hFFC, 32'hFFC, rxam_pkg::REGION_NONE);
		xl(32'h1000, 32'h8000_0000, rxam_pkg::REGION_TWO);
		xl(32'h1FFC, 32'h8000_0FFC, rxam_pkg::REGION_TWO);
		xl(32'h2000, 32'h4000_0000, rxam_pkg::REGION_THREE);
		xl(32'h3FFC, 32'h4000_1FFC, rxam_pkg::REGION_THREE);
		xl(32'h4000, 32'h5000_0000, rxam_pkg::REGION_FOUR);
		xl(32'h4FFC, 32'h5000_0FFC, rxam_pkg::REGION_FOUR);
		xl(32'h5000, 32'h5000, rxam_pkg::REGION_NONE);
	endtask
	task automatic t_shift;
		@(posedge mclk);
		region1_span <= 32'h0;
		region2_span <= 32'h800;
		region2_base_offset <= 32'h1234_0000;
		xl(32'h0, 32'h1234_0000, rxam_pkg::REGION_TWO);
		xl(32'h7FC, 32'h1234_07FC, rxam_pkg::REGION_TWO);
		xl(32'h800, 32'h4000_0000, rxam_pkg::REGION_THREE);
		xl(32'h37FC, 32'h5000_0FFC, rxam_pkg::REGION_FOUR);
		xl(32'h3800, 32'h3800, rxam_pkg::REGION_NONE);
	endtask
	task automatic t_rst2;
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'h30 + 8'(4 * i), 32'h0);
			chk("field after mid-run reset", rd, 32'h0);
		end
		xl(32'h800, 32'h800, rxam_pkg::REGION_NONE);
	endtask

	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		t_reset();
		t_fields();
		t_ident();
		t_xlat();
		t_shift();
		t_rst2();
		end_of_test();
	end
	initial begin
		#40000;
		err_total++;
		end_of_test();
	end
endmodule
